// ### pkg/adc_cfg.svh
// Purpose: Offsets, field positions, reset values and divider figures of the converter control
// Assumes: Byte address of a register is four times its index
// Notes: Definitions only
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

`define ADC_IDX_FIRST 10'h3d6
`define ADC_IDX_SECOND 10'h3d7
`define ADC_IDX_THIRD 10'h3d4
`define ADC_IDX_STATUS 10'h3d5
`define ADC_IDX_RESULT0 10'h3c0
`define ADC_RESULT_CNT 10'h008

`define ADC_FIRST_RST 8'h00
`define ADC_SECOND_RST 8'h00
`define ADC_THIRD_RST 8'h00

`define ADC_CH_MSB 2
`define ADC_CH_LSB 0
`define ADC_MODE_LO0_BIT 3
`define ADC_MODE_LO1_BIT 4
`define ADC_TRIG_SEL_BIT 5
`define ADC_START_BIT 6
`define ADC_DIV0_BIT 7

`define ADC_SCAN_MSB 1
`define ADC_SCAN_LSB 0
`define ADC_MODE_HI_BIT 2
`define ADC_DIV1_BIT 4
`define ADC_STBY_BIT 5
`define ADC_EX_MSB 7
`define ADC_EX_LSB 6

`define ADC_GSEL_MSB 1
`define ADC_GSEL_LSB 0
`define ADC_DIV2_BIT 4

`define ADC_EX_NONE 2'h0
`define ADC_EX_IN0 2'h1
`define ADC_EX_IN1 2'h2

`define ADC_DIV_CODE_BY4 3'h0
`define ADC_DIV_CODE_BY2 3'h1
`define ADC_DIV_CODE_BY6 3'h5
`define ADC_DIV_CODE_BY3 3'h6
`define ADC_DIV_BY2 4'h2
`define ADC_DIV_BY3 4'h3
`define ADC_DIV_BY4 4'h4
`define ADC_DIV_BY6 4'h6
`define ADC_DIV_LOAD_RST 4'h1

`endif

// ### pkg/adc_pkg.sv
// Purpose: Types shared by the converter control logic
// Assumes: Constants live in adc_cfg.svh
// Notes: Mode enum lists only the five legal mode codes
package adc_pkg;

  typedef enum logic [2:0] {
    MODE_ONE_SHOT,
    MODE_REPEAT,
    MODE_SINGLE_SWEEP,
    MODE_REPEAT_SWEEP0,
    MODE_REPEAT_SWEEP1
  } op_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_TRIG,
    ST_ISSUE,
    ST_CONV
  } seq_state_e;

endpackage : adc_pkg

// ### design/sample_clk_divider.sv
// Purpose: Sampling clock enable generator on fAD
// Assumes: Divider code is one of the four legal codes
// Notes: Unlisted codes fall back to divide by 4
`timescale 1ns/1ns
`include "adc_cfg.svh"

module sample_clk_divider #(
  parameter int CNT_W = 4
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [2:0] div_code,
  output logic tick
);

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic [CNT_W-1:0] reload;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    case (div_code)
      `ADC_DIV_CODE_BY2: reload = CNT_W'(`ADC_DIV_BY2);
      `ADC_DIV_CODE_BY3: reload = CNT_W'(`ADC_DIV_BY3);
      `ADC_DIV_CODE_BY6: reload = CNT_W'(`ADC_DIV_BY6);
      default: reload = CNT_W'(`ADC_DIV_BY4);
    endcase
    // Reload on terminal count so a code change takes effect at the next period
    tick_nxt = (count_r == CNT_W'(`ADC_DIV_LOAD_RST));
    count_nxt = tick_nxt ? reload : count_r - CNT_W'(1);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      count_r <= CNT_W'(`ADC_DIV_LOAD_RST);
      tick_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

  AST_DIV_GAP: assert property (@(posedge clock) disable iff (srst)
    tick_r |=> !tick_r)
    else $error("sample clock enable lasted two cycles");

endmodule : sample_clk_divider

// ### design/adc_control.sv
// Purpose: Mode, channel, trigger, divider and standby control of a sampling converter
// Assumes: APB slave; analog core converts one input per conv_req and pulses core_result_valid
// Notes: No wait states; every APB access completes in its first access cycle
`timescale 1ns/1ns
`include "adc_cfg.svh"

module adc_control #(
  parameter int RES_W = 10,
  parameter int ADDR_W = 12
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_trigger_pin,
  input wire logic [RES_W-1:0] core_result,
  input wire logic core_result_valid,
  output logic analog_enable,
  output logic conv_req,
  output logic [1:0] input_group_sel,
  output logic [2:0] input_index,
  output logic [1:0] extended_input_sel,
  output logic sample_clk_en
);

  // Register and bus state
  logic [7:0] ctrl_first_r, ctrl_first_nxt;
  logic [7:0] ctrl_second_r, ctrl_second_nxt;
  logic [7:0] ctrl_third_r, ctrl_third_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  // Sequencer state
  adc_pkg::seq_state_e state_r, state_nxt;
  logic [2:0] slot_r, slot_nxt;
  logic [RES_W-1:0] result_r [8];
  logic [RES_W-1:0] result_nxt [8];
  logic conv_req_r, conv_req_nxt;
  logic [1:0] group_r, group_nxt;
  logic [2:0] index_r, index_nxt;
  logic [1:0] ext_r, ext_nxt;
  logic analog_en_r, analog_en_nxt;
  logic hw_clear_start;

  // Trigger pin synchroniser
  logic trig_s1_r, trig_s2_r, trig_prev_r;
  logic trig_fall;

  // Decoded controls
  adc_pkg::op_mode_e mode;
  logic sweep_mode, stop_after_last, start_flag, standby_on, tick;
  logic [2:0] last_slot, first_slot, div_code;
  logic [1:0] ext_sel;

  logic [ADDR_W-3:0] word_idx, res_off;
  logic hit_first, hit_second, hit_third, hit_status, hit_result;
  logic wr_access, sw_set_start;

  assign word_idx = paddr[ADDR_W-1:2];
  assign res_off = word_idx - (ADDR_W-2)'(`ADC_IDX_RESULT0);
  assign hit_first = (word_idx == (ADDR_W-2)'(`ADC_IDX_FIRST));
  assign hit_second = (word_idx == (ADDR_W-2)'(`ADC_IDX_SECOND));
  assign hit_third = (word_idx == (ADDR_W-2)'(`ADC_IDX_THIRD));
  assign hit_status = (word_idx == (ADDR_W-2)'(`ADC_IDX_STATUS));
  assign hit_result = (res_off < (ADDR_W-2)'(`ADC_RESULT_CNT));
  assign wr_access = psel && penable && pready_r && pwrite;
  assign sw_set_start = wr_access && hit_first && pwdata[`ADC_START_BIT];

  assign start_flag = ctrl_first_r[`ADC_START_BIT];
  assign standby_on = ctrl_second_r[`ADC_STBY_BIT];
  assign ext_sel = ctrl_second_r[`ADC_EX_MSB:`ADC_EX_LSB];
  assign div_code = {ctrl_third_r[`ADC_DIV2_BIT], ctrl_second_r[`ADC_DIV1_BIT],
                     ctrl_first_r[`ADC_DIV0_BIT]};
  assign trig_fall = trig_prev_r && !trig_s2_r;

  // Illegal mode codes fall back to one-shot so the sequencer never hangs
  always_comb begin
    case ({ctrl_second_r[`ADC_MODE_HI_BIT], ctrl_first_r[`ADC_MODE_LO1_BIT],
           ctrl_first_r[`ADC_MODE_LO0_BIT]})
      3'h1: mode = adc_pkg::MODE_REPEAT;
      3'h2: mode = adc_pkg::MODE_SINGLE_SWEEP;
      3'h3: mode = adc_pkg::MODE_REPEAT_SWEEP0;
      3'h7: mode = adc_pkg::MODE_REPEAT_SWEEP1;
      default: mode = adc_pkg::MODE_ONE_SHOT;
    endcase
    sweep_mode = (mode == adc_pkg::MODE_SINGLE_SWEEP) || (mode == adc_pkg::MODE_REPEAT_SWEEP0) ||
                 (mode == adc_pkg::MODE_REPEAT_SWEEP1);
    stop_after_last = (mode == adc_pkg::MODE_ONE_SHOT) || (mode == adc_pkg::MODE_SINGLE_SWEEP);
    if (mode == adc_pkg::MODE_REPEAT_SWEEP1) begin
      last_slot = {1'b0, ctrl_second_r[`ADC_SCAN_MSB:`ADC_SCAN_LSB]};
    end else begin
      last_slot = {ctrl_second_r[`ADC_SCAN_MSB:`ADC_SCAN_LSB], 1'b1};
    end
    if (sweep_mode) begin
      first_slot = 3'h0;
    end else if (ext_sel == `ADC_EX_IN0) begin
      first_slot = 3'h0;
    end else if (ext_sel == `ADC_EX_IN1) begin
      first_slot = 3'h1;
    end else begin
      first_slot = ctrl_first_r[`ADC_CH_MSB:`ADC_CH_LSB];
    end
  end

  sample_clk_divider #(
    .CNT_W(4)
  ) u_divider (
    .clock(clock),
    .srst(srst),
    .div_code(div_code),
    .tick(tick)
  );

  // Register file and APB answer
  always_comb begin
    ctrl_first_nxt = ctrl_first_r;
    ctrl_second_nxt = ctrl_second_r;
    ctrl_third_nxt = ctrl_third_r;
    // Clear first so a software set in the same cycle wins
    if (hw_clear_start) begin
      ctrl_first_nxt[`ADC_START_BIT] = 1'b0;
    end
    // Writes mid-conversion are taken as is; the core result is then undefined
    if (wr_access && hit_first) begin
      ctrl_first_nxt = pwdata[7:0];
    end
    if (wr_access && hit_second) begin
      ctrl_second_nxt = pwdata[7:0];
    end
    if (wr_access && hit_third) begin
      ctrl_third_nxt = pwdata[7:0];
    end
    pready_nxt = psel && !penable;
    pslverr_nxt = psel && !penable &&
                  !(hit_first || hit_second || hit_third || hit_status || hit_result);
    prdata_nxt = 32'h0;
    if (psel && !penable && !pwrite) begin
      if (hit_first) begin
        prdata_nxt = {24'h0, ctrl_first_r};
      end else if (hit_second) begin
        prdata_nxt = {24'h0, ctrl_second_r};
      end else if (hit_third) begin
        prdata_nxt = {24'h0, ctrl_third_r};
      end else if (hit_status) begin
        prdata_nxt = {28'h0, slot_r, state_r != adc_pkg::ST_IDLE};
      end else if (hit_result) begin
        prdata_nxt = 32'(result_r[res_off[2:0]]);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_first_r <= `ADC_FIRST_RST;
      ctrl_second_r <= `ADC_SECOND_RST;
      ctrl_third_r <= `ADC_THIRD_RST;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_first_r <= ctrl_first_nxt;
      ctrl_second_r <= ctrl_second_nxt;
      ctrl_third_r <= ctrl_third_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Conversion sequencer
  always_comb begin
    state_nxt = state_r;
    slot_nxt = slot_r;
    result_nxt = result_r;
    conv_req_nxt = 1'b0;
    group_nxt = group_r;
    index_nxt = index_r;
    ext_nxt = ext_r;
    hw_clear_start = 1'b0;
    analog_en_nxt = standby_on;
    case (state_r)
      adc_pkg::ST_IDLE: begin
        if (start_flag && standby_on) begin
          slot_nxt = first_slot;
          state_nxt = ctrl_first_r[`ADC_TRIG_SEL_BIT] ? adc_pkg::ST_WAIT_TRIG
                                                 : adc_pkg::ST_ISSUE;
        end
      end
      adc_pkg::ST_WAIT_TRIG: begin
        if (!start_flag || !standby_on) begin
          state_nxt = adc_pkg::ST_IDLE;
        end else if (trig_fall) begin
          state_nxt = adc_pkg::ST_ISSUE;
        end
      end
      adc_pkg::ST_ISSUE: begin
        if (!start_flag || !standby_on) begin
          state_nxt = adc_pkg::ST_IDLE;
        end else if (tick) begin
          conv_req_nxt = 1'b1;
          group_nxt = ctrl_third_r[`ADC_GSEL_MSB:`ADC_GSEL_LSB];
          index_nxt = slot_r;
          ext_nxt = (sweep_mode || ext_sel == 2'h3) ? `ADC_EX_NONE : ext_sel;
          state_nxt = adc_pkg::ST_CONV;
        end
      end
      adc_pkg::ST_CONV: begin
        if (!start_flag || !standby_on) begin
          state_nxt = adc_pkg::ST_IDLE;
        end else if (core_result_valid) begin
          result_nxt[slot_r] = core_result;
          if (!sweep_mode || slot_r >= last_slot) begin
            slot_nxt = first_slot;
            if (stop_after_last) begin
              hw_clear_start = 1'b1;
              state_nxt = adc_pkg::ST_IDLE;
            end else begin
              state_nxt = adc_pkg::ST_ISSUE;
            end
          end else begin
            slot_nxt = slot_r + 3'h1;
            state_nxt = adc_pkg::ST_ISSUE;
          end
        end
      end
      default: state_nxt = adc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= adc_pkg::ST_IDLE;
      slot_r <= 3'h0;
      for (int i = 0; i < 8; i++) begin
        result_r[i] <= '0;
      end
      conv_req_r <= 1'b0;
      group_r <= 2'h0;
      index_r <= 3'h0;
      ext_r <= `ADC_EX_NONE;
      analog_en_r <= 1'b0;
      trig_s1_r <= 1'b1;
      trig_s2_r <= 1'b1;
      trig_prev_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      slot_r <= slot_nxt;
      result_r <= result_nxt;
      conv_req_r <= conv_req_nxt;
      group_r <= group_nxt;
      index_r <= index_nxt;
      ext_r <= ext_nxt;
      analog_en_r <= analog_en_nxt;
      trig_s1_r <= external_trigger_pin;
      trig_s2_r <= trig_s1_r;
      trig_prev_r <= trig_s2_r;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign analog_enable = analog_en_r;
  assign conv_req = conv_req_r;
  assign input_group_sel = group_r;
  assign input_index = index_r;
  assign extended_input_sel = ext_r;
  assign sample_clk_en = tick;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  AST_STANDBY_NO_REQ: assert property (!standby_on |=> !conv_req_r)
    else $error("conversion requested while in standby");
  AST_STANDBY_POWER: assert property (##1 analog_en_r == $past(standby_on))
    else $error("analog enable does not follow standby bit");
  AST_ONESHOT_CLEAR: assert property (
    (state_r == adc_pkg::ST_CONV) && core_result_valid && start_flag && standby_on &&
    (mode == adc_pkg::MODE_ONE_SHOT) && !sw_set_start && !(wr_access && hit_first)
    |=> !start_flag && (state_r == adc_pkg::ST_IDLE))
    else $error("start flag not cleared after one-shot result");
  AST_SET_WINS: assert property (sw_set_start |=> start_flag)
    else $error("software set of start flag was lost");
  AST_RESULT_STORE: assert property (
    (state_r == adc_pkg::ST_CONV) && core_result_valid && start_flag && standby_on
    |=> result_r[$past(slot_r)] == $past(core_result))
    else $error("result not stored in its register");
  AST_SWEEP_RANGE: assert property (
    conv_req_r && (mode != adc_pkg::MODE_ONE_SHOT) && (mode != adc_pkg::MODE_REPEAT)
    |-> index_r <= last_slot && ext_r == `ADC_EX_NONE)
    else $error("sweep went past its last input");
  AST_MODE_HIGH: assert property (
    conv_req_r && ctrl_second_r[`ADC_MODE_HI_BIT] |-> index_r <= 3'h3)
    else $error("high mode bit did not select the short sweep table");
  AST_EXT_TRIGGER: assert property (
    (state_r == adc_pkg::ST_WAIT_TRIG) && !trig_fall && start_flag && standby_on
    |=> state_r == adc_pkg::ST_WAIT_TRIG)
    else $error("external trigger mode left wait without a falling edge");
  AST_REQ_ON_TICK: assert property ($rose(conv_req_r) |-> $past(tick))
    else $error("conversion not aligned to sampling clock");
  AST_APB_ANSWER: assert property (psel && !penable ##1 psel && penable |-> pready_r)
    else $error("APB access not answered after setup");

  COV_ONESHOT: cover property (conv_req_r ##[1:50] hw_clear_start);
  COV_SWEEP_WRAP: cover property ((mode == adc_pkg::MODE_REPEAT_SWEEP0) && conv_req_r &&
                                  (index_r == 3'h7));
  COV_EXT_TRIG: cover property ((state_r == adc_pkg::ST_WAIT_TRIG) ##1
                                (state_r == adc_pkg::ST_ISSUE));
  COV_EXT_INPUT: cover property (conv_req_r && (ext_r == `ADC_EX_IN1));

endmodule : adc_control

// ### dv/analog_core_model.sv
// Purpose: Behavioural model of the analog conversion core behind the control block
// Assumes: One conversion in flight at a time; answer comes LAT cycles after conv_req
// Notes: Result encodes group, extended select and slot so the bench can tell slots apart
`timescale 1ns/1ns

module analog_core_model #(
  parameter int LAT = 5
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic conv_req,
  input wire logic [1:0] grp,
  input wire logic [1:0] ext,
  input wire logic [2:0] idx,
  output logic [9:0] core_result,
  output logic core_result_valid
);
  int cnt;
  logic [9:0] val;

  always @(posedge clock) begin
    if (srst) begin
      cnt <= 0;
      val <= 10'h000;
      core_result_valid <= 1'b0;
      core_result <= 10'h155;
    end else begin
      core_result_valid <= 1'b0;
      // Bus is not held outside the valid pulse, so stale data must not look good
      core_result <= ~core_result;
      if (conv_req === 1'b1) begin
        cnt <= LAT;
        val <= {1'b1, grp, ext, 2'h1, idx};
      end else if (cnt == 1) begin
        cnt <= 0;
        core_result_valid <= 1'b1;
        core_result <= val;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : analog_core_model

// ### dv/test_adc_control.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Divider left at divide by 3 once the divider table has been walked
// Notes: Outputs are read right after a rising edge, so they are the prior cycle's values
`timescale 1ns/1ns
`include "adc_cfg.svh"

module test_adc_control;
  localparam logic [11:0] A_FIRST = {`ADC_IDX_FIRST, 2'h0};
  localparam logic [11:0] A_SECOND = {`ADC_IDX_SECOND, 2'h0};
  localparam logic [11:0] A_THIRD = {`ADC_IDX_THIRD, 2'h0};
  localparam logic [11:0] A_RES0 = {`ADC_IDX_RESULT0, 2'h0};
  localparam logic [11:0] A_STATUS = {`ADC_IDX_STATUS, 2'h0};
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_pin = 1'b1;
  logic [9:0] core_result;
  logic core_result_valid;
  logic analog_enable;
  logic conv_req;
  logic [1:0] input_group_sel;
  logic [2:0] input_index;
  logic [1:0] extended_input_sel;
  logic sample_clk_en;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  int gap;
  logic [31:0] rdv;
  logic err;
  logic [6:0] got;

  always #10 clock = ~clock;

  adc_control u_dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_trigger_pin(ext_pin), .core_result(core_result),
    .core_result_valid(core_result_valid), .analog_enable(analog_enable),
    .conv_req(conv_req), .input_group_sel(input_group_sel), .input_index(input_index),
    .extended_input_sel(extended_input_sel), .sample_clk_en(sample_clk_en));

  analog_core_model u_core (.clock(clock), .srst(srst), .conv_req(conv_req),
    .grp(input_group_sel), .ext(extended_input_sel), .idx(input_index),
    .core_result(core_result), .core_result_valid(core_result_valid));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Upper write bits are set on purpose: only the low byte may be stored
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'hffffff, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    check("read data", rdv, exp);
    check("read error", {31'h0, err}, 32'h0);
  endtask : rd_chk

  task automatic wait_req();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (conv_req !== 1'b1 && n < 400);
    got = {input_group_sel, extended_input_sel, input_index};
    check("conv_req", {31'h0, conv_req}, 32'h1);
  endtask : wait_req

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clock);
      check("no conv_req", {31'h0, conv_req}, 32'h0);
    end
  endtask : quiet

  task automatic run(input logic [7:0] c3, c2, c1, input int n, span,
    input logic [2:0] base, input logic [1:0] ext, grp);
    apb(1'b1, A_THIRD, c3);
    apb(1'b1, A_SECOND, c2);
    apb(1'b1, A_FIRST, c1);
    for (int k = 0; k < n; k++) begin
      wait_req();
      check("slot", {25'h0, got}, {25'h0, grp, ext, base + 3'(k % span)});
    end
  endtask : run

  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    rd_chk(A_FIRST, 32'h0);
    rd_chk(A_SECOND, 32'h0);
    rd_chk(A_THIRD, 32'h0);
    apb(1'b0, 12'h000, 8'h00);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped data", rdv, 32'h0);
    apb(1'b1, A_FIRST, 8'hbf);
    rd_chk(A_FIRST, 32'hbf);
    // Start with standby low must never reach the core
    apb(1'b1, A_FIRST, 8'h40);
    rd_chk(A_FIRST, 32'h40);
    quiet(40);
    check("analog off", {31'h0, analog_enable}, 32'h0);
    apb(1'b1, A_FIRST, 8'h00);
    // Divider codes with standby on; analog enable is checked once the table walk ends
    for (int i = 0; i < 4; i++) begin
      logic [2:0] c;
      logic [3:0] dv;
      c = (i == 0) ? 3'h0 : (i == 1) ? 3'h1 : (i == 2) ? 3'h5 : 3'h6;
      dv = (i == 0) ? 4'h4 : (i == 1) ? 4'h2 : (i == 2) ? 4'h6 : 4'h3;
      apb(1'b1, A_THIRD, {3'h0, c[2], 4'h0});
      apb(1'b1, A_SECOND, {2'h0, 1'b1, c[1], 4'h0});
      apb(1'b1, A_FIRST, {c[0], 7'h0});
      repeat (3) begin
        gap = 0;
        do begin
          @(posedge clock);
          gap++;
        end while (sample_clk_en !== 1'b1 && gap < 20);
      end
      check("tick gap", 32'(gap), {28'h0, dv});
    end
    check("analog on", {31'h0, analog_enable}, 32'h1);
    // One-shot on every channel and group; sweep field set to 11 and ignored
    for (int ch = 0; ch < 8; ch++) begin
      run({6'h04, 2'(ch)}, 8'h33, {5'h08, 3'(ch)}, 1, 1, 3'(ch), 2'h0, 2'(ch));
      repeat (20) @(posedge clock);
      rd_chk(A_FIRST, {29'h0, 3'(ch)});
      rd_chk(A_RES0 + 12'(4 * ch), {22'h0, 1'b1, 2'(ch), 2'h0, 2'h1, 3'(ch)});
    end
    for (int e = 1; e < 3; e++) begin
      run(8'h10, {2'(e), 6'h30}, 8'h45, 1, 1, 3'(e - 1), 2'(e), 2'h0);
      repeat (20) @(posedge clock);
      rd_chk(A_RES0 + 12'(4 * (e - 1)), {22'h0, 3'h4, 2'(e), 2'h1, 3'(e - 1)});
    end
    run(8'h10, 8'h31, 8'h57, 4, 4, 3'h0, 2'h0, 2'h0);
    quiet(30);
    rd_chk(A_FIRST, 32'h17);
    for (int s = 0; s < 4; s++) begin
      run(8'h10, {6'h0c, 2'(s)}, 8'h58, 2 * s + 3, 2 * s + 2, 3'h0, 2'h0, 2'h0);
      apb(1'b1, A_FIRST, 8'h18);
      apb(1'b1, A_FIRST, 8'h18);
      run(8'h10, {6'h0d, 2'(s)}, 8'h58, s + 2, s + 1, 3'h0, 2'h0, 2'h0);
      apb(1'b1, A_FIRST, 8'h18);
      apb(1'b1, A_SECOND, 8'h30);
    end
    run(8'h10, 8'h30, 8'h4b, 3, 1, 3'h3, 2'h0, 2'h0);
    apb(1'b1, A_FIRST, 8'h08);
    repeat (20) @(posedge clock);
    // Pin trigger: nothing until a falling edge, pin held low well over two cycles
    apb(1'b1, A_FIRST, 8'h62);
    quiet(40);
    rd_chk(A_STATUS, 32'h5);
    ext_pin <= 1'b0;
    wait_req();
    check("pin slot", {29'h0, got[2:0]}, 32'h2);
    ext_pin <= 1'b1;
    repeat (20) @(posedge clock);
    rd_chk(A_FIRST, 32'h22);
    rd_chk(A_STATUS, 32'h4);
    wrap_up();
  end
endmodule : test_adc_control
